/* File: include/imc_cfg.svh */
// offsets, field positions, reset values and source count for the source mode config block
`ifndef IMC_CFG_SVH
`define IMC_CFG_SVH
`define IMC_REG_ADDR 32'hFFFFE010
`define IMC_REG_RESET 32'h00000000
`define IMC_SRC_STRIDE 8
`define IMC_LVL_LSB 0
`define IMC_DMA_BIT 3
`define IMC_SENS_LSB 4
`define IMC_SENS_RISING 2'h3
`define IMC_NUM_SRC 4
`define IMC_FIRST_SRC 16
`define IMC_UNMAPPED_DATA 32'h00000000
`endif

/* File: include/imc_pkg.sv */
// types shared by the source mode config block
package imc_pkg;
  typedef logic [2:0] imc_field_t;
  typedef logic [1:0] imc_sens_t;
  typedef enum logic [1:0] {
    IMC_IDLE,
    IMC_ACK
  } imc_bus_e;
  typedef struct packed {
    imc_sens_t sens;
    logic dma_en;
    imc_field_t field;
  } imc_src_s;
endpackage : imc_pkg

/* File: hw/imc_src_route.sv */
// per-source route: turns one event into an interrupt request or a dma request
`timescale 1ns/1ps
`default_nettype none
module imc_src_route (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic event_in,
  input wire logic dma_en,
  input wire logic [2:0] field,
  output logic int_req,
  output logic [2:0] int_level,
  output logic dma_req,
  output logic [2:0] dma_chan
);
  logic prev_ev; // last event level for edge detection
  logic next_prev_ev;
  logic next_int_req;
  logic next_dma_req;
  logic [2:0] next_int_level;
  logic [2:0] next_dma_chan;
  logic rise;

  //////////////////////////////////////////////////////////////////////
  // rising-edge sensing; only rising edge is a legal sensitivity
  always_comb begin
    rise = event_in & ~prev_ev;
    next_prev_ev = event_in;
    // dma mode: field is a channel number 0..7, no interrupt
    next_dma_req = rise & dma_en;
    next_dma_chan = dma_en ? field : 3'h0;
    // interrupt mode: field is priority, zero disables
    next_int_req = rise & ~dma_en & (field != 3'h0);
    next_int_level = dma_en ? 3'h0 : field;
  end

  // registered outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev_ev <= 1'b0;
      int_req <= 1'b0;
      dma_req <= 1'b0;
      int_level <= 3'h0;
      dma_chan <= 3'h0;
    end else begin
      prev_ev <= next_prev_ev;
      int_req <= next_int_req;
      dma_req <= next_dma_req;
      int_level <= next_int_level;
      dma_chan <= next_dma_chan;
    end
  end
endmodule : imc_src_route
`default_nettype wire

/* File: hw/imc_avmm_slave.sv */
// avalon-mm slave front end, one wait cycle per access
`timescale 1ns/1ps
`default_nettype none
module imc_avmm_slave (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  output logic waitrequest,
  output logic acc_go
);
  imc_pkg::imc_bus_e state; // access phase
  imc_pkg::imc_bus_e next_state;

  //////////////////////////////////////////////////////////////////////
  // first request cycle waits, second completes; keeps timing simple
  always_comb begin
    next_state = state;
    case (state)
      imc_pkg::IMC_IDLE: begin
        if (read | write) begin
          next_state = imc_pkg::IMC_ACK;
        end
      end
      imc_pkg::IMC_ACK: begin
        next_state = imc_pkg::IMC_IDLE;
      end
      default: begin
        next_state = imc_pkg::IMC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= imc_pkg::IMC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // waitrequest low only in the completing cycle
  assign acc_go = (state == imc_pkg::IMC_ACK) & (read | write);
  assign waitrequest = ~acc_go;
endmodule : imc_avmm_slave
`default_nettype wire

/* File: hw/imc_mode_config.sv */
// mode configuration register for interrupt sources 16 to 19 with routing
//
// Local design decision: the Avalon-MM interface to the registers.
`include "imc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - dma bit clear: field is priority level
// - zero disables; 1..7 are levels directly
// - dma bit set: field selects dma channel
// - codes 0..3 select dma channels 0..3
// - dma bit picks interrupt or dma trigger
// - codes 4..7 select dma channels 4..7
module imc_mode_config #(
  parameter int NUM_SRC = `IMC_NUM_SRC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic serial0_receive_event,
  input wire logic serial0_transmit_event,
  input wire logic serial1_receive_event,
  input wire logic serial1_transmit_event,
  output logic [NUM_SRC-1:0] int_req,
  output logic [3*NUM_SRC-1:0] int_level,
  output logic [NUM_SRC-1:0] dma_req,
  output logic [3*NUM_SRC-1:0] dma_chan,
  output logic sens_violation
);
  logic [31:0] int_mode_config_sources_16_19; // the config word
  logic [31:0] next_cfg;
  logic [31:0] next_readdata;
  logic next_violation;
  logic acc_go; // bus access completes this cycle
  logic hit; // address matches the register
  logic [NUM_SRC-1:0] events;

  //////////////////////////////////////////////////////////////////////
  // field extraction helper, used for every source, and the byte-enable write merge
  function automatic imc_pkg::imc_src_s imc_src_of(input logic [31:0] w, input int i);
    imc_pkg::imc_src_s s;
    s = imc_pkg::imc_src_s'(w[i*`IMC_SRC_STRIDE +: 6]);
    return s;
  endfunction : imc_src_of

  function automatic logic [31:0] imc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    // bits 6,7 of each byte are reserved and read zero
    return r & 32'h3F3F3F3F;
  endfunction : imc_merge

  //////////////////////////////////////////////////////////////////////
  // bus front end
  imc_avmm_slave u_bus (
    .core_clk(core_clk),
    .rst(rst),
    .read(read),
    .write(write),
    .waitrequest(waitrequest),
    .acc_go(acc_go)
  );

  assign hit = (address == `IMC_REG_ADDR);

  // register update and read data
  always_comb begin
    next_cfg = int_mode_config_sources_16_19;
    next_readdata = readdata;
    next_violation = sens_violation;
    if (acc_go & write & hit) begin
      next_cfg = imc_merge(int_mode_config_sources_16_19, writedata, byteenable);
      // flag any source left at a non-rising code; device still stores it
      next_violation = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
        if (imc_src_of(next_cfg, i).sens != `IMC_SENS_RISING) begin
          next_violation = 1'b1;
        end
      end
    end
    if (read & ~acc_go) begin
      // load in the wait cycle so the data stand at the completing edge
      // unmapped reads return zero, writes there are dropped
      next_readdata = hit ? int_mode_config_sources_16_19 : `IMC_UNMAPPED_DATA;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      int_mode_config_sources_16_19 <= `IMC_REG_RESET;
      readdata <= 32'h00000000;
      sens_violation <= 1'b0;
    end else begin
      int_mode_config_sources_16_19 <= next_cfg;
      readdata <= next_readdata;
      sens_violation <= next_violation;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // source routing: source 16+i, events in number order
  assign events = {serial1_transmit_event, serial1_receive_event,
                   serial0_transmit_event, serial0_receive_event};

  for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
    imc_pkg::imc_src_s s;
    assign s = imc_src_of(int_mode_config_sources_16_19, g);
    // mode split lives in the route cell
    imc_src_route u_route (
      .core_clk(core_clk),
      .rst(rst),
      .event_in(events[g]),
      .dma_en(s.dma_en),
      .field(s.field),
      .int_req(int_req[g]),
      .int_level(int_level[g*3 +: 3]),
      .dma_req(dma_req[g]),
      .dma_chan(dma_chan[g*3 +: 3])
    );
  end
endmodule : imc_mode_config
`default_nettype wire

/* File: bench/imc_mode_config_asserts.sv */
// checker on the config block ports
`timescale 1ns/1ps
`default_nettype none
module imc_mode_config_asserts (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [31:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic serial0_receive_event,
  input wire logic [3:0] int_req,
  input wire logic [11:0] int_level,
  input wire logic [3:0] dma_req,
  input wire logic [11:0] dma_chan
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("slow answer");
  a_reset_quiet: assert property ($fell(rst) |-> !int_req && !dma_req && !readdata) else $error("dirty reset");
  a_route_excl: assert property (!(int_req & dma_req)) else $error("both routes");
  a_req_cause: assert property (int_req[0] || dma_req[0] |->
    $past(serial0_receive_event) && !$past(serial0_receive_event, 2)) else $error("no cause");
  a_lvl_nonzero: assert property (int_req[0] |-> int_level[2:0] != 3'h0) else $error("level 0");
  a_chan_quiet: assert property (int_req[0] |-> dma_chan[2:0] == 3'h0) else $error("chan set");
  a_lvl_quiet: assert property (dma_req[0] |-> int_level[2:0] == 3'h0) else $error("level set");
  a_unmapped_zero: assert property (read && !waitrequest && address != 32'hFFFFE010 |-> readdata == 32'h0)
    else $error("unmapped data");
  a_reserved_zero: assert property (read && !waitrequest |-> (readdata & 32'hC0C0C0C0) == 32'h0)
    else $error("reserved set");
endmodule : imc_mode_config_asserts
bind imc_mode_config imc_mode_config_asserts chk_u (.core_clk, .rst, .address, .read, .write, .readdata,
  .waitrequest, .serial0_receive_event, .int_req, .int_level, .dma_req, .dma_chan);
`default_nettype wire

/* File: bench/imc_req_sink.sv */
// partner: request sink for the core and dma controller
`timescale 1ns/1ps
`default_nettype none
module imc_req_sink (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic [3:0] int_req,
  input wire logic [11:0] int_level,
  input wire logic [3:0] dma_req,
  input wire logic [11:0] dma_chan,
  output logic [3:0] hit_int,
  output logic [3:0] hit_dma,
  output logic [11:0] got
);
  // sticky hits and last level or channel, so a missed pulse shows
  always_ff @(posedge core_clk) begin
    if (clr) begin
      {hit_int, hit_dma, got} <= 20'h0;
    end else begin
      hit_int <= hit_int | int_req;
      hit_dma <= hit_dma | dma_req;
      for (int i = 0; i < 4; i++) begin
        if (int_req[i]) got[3*i+:3] <= int_level[3*i+:3];
        if (dma_req[i]) got[3*i+:3] <= dma_chan[3*i+:3];
      end
    end
  end
endmodule : imc_req_sink
`default_nettype wire

/* File: bench/tb.sv */
// testbench for the source mode config block
`include "imc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, clr = 1'b0, waitrequest, sens_violation;
  logic [31:0] address = 32'h0, writedata = 32'h0, readdata, rv, e;
  logic [3:0] byteenable = 4'h0, ev = 4'h0, int_req, dma_req, hit_int, hit_dma;
  logic [11:0] int_level, dma_chan, got;
  int n_mismatch = 0, cmp_count = 0, cyc = 0;
  initial forever #5 core_clk = ~core_clk;
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end
  imc_mode_config dut_u (.core_clk, .rst, .address, .read, .write, .byteenable, .writedata, .readdata,
    .waitrequest, .serial0_receive_event(ev[0]), .serial0_transmit_event(ev[1]),
    .serial1_receive_event(ev[2]), .serial1_transmit_event(ev[3]), .int_req, .int_level, .dma_req,
    .dma_chan, .sens_violation);
  imc_req_sink sink_u (.core_clk, .clr, .int_req, .int_level, .dma_req, .dma_chan, .hit_int, .hit_dma, .got);
  ////////////////////////////////////////
  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  // one bus access; readdata is registered, so taken at the negedge where waitrequest is low, before the completing edge
  task automatic acc(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
    logic done;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= w;
    read <= !w;
    do begin
      @(negedge core_clk);
      done = (waitrequest === 1'b0);
      rv = readdata;
      @(posedge core_clk);
    end while (!done);
    write <= 1'b0;
    read <= 1'b0;
  endtask : acc
  // raise events on the chosen sources, then drop them
  task automatic fire(input logic [3:0] m);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    ev <= m;
    repeat (3) @(posedge core_clk);
    ev <= 4'h0;
    @(posedge core_clk);
    #1;
  endtask : fire
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    acc(1'b0, `IMC_REG_ADDR, 32'h0, 4'h0); chk(rv, `IMC_REG_RESET);
    acc(1'b1, 32'hFFFFE014, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, 32'hFFFFE014, 32'h0, 4'h0); chk(rv, `IMC_UNMAPPED_DATA);
    acc(1'b0, `IMC_REG_ADDR, 32'h0, 4'h0); chk(rv, 32'h0);
    // every code in both modes, on all four sources at once
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        e = {4{2'b00, `IMC_SENS_RISING, m[0], c[2:0]}};
        acc(1'b1, `IMC_REG_ADDR, e, 4'hF);
        acc(1'b0, `IMC_REG_ADDR, 32'h0, 4'h0); chk(rv, e);
        fire(4'hF);
        chk({hit_int, hit_dma}, m ? 8'h0F : (c == 0 ? 8'h00 : 8'hF0));
        chk(got, (m == 0 && c == 0) ? 12'h0 : {4{c[2:0]}});
      end
    end
    acc(1'b1, `IMC_REG_ADDR, 32'hFFFFFF00, 4'h1);
    acc(1'b0, `IMC_REG_ADDR, 32'h0, 4'h0); chk(rv, {e[31:8], 8'h00});
    chk({31'h0, sens_violation}, 32'h1);
    acc(1'b1, `IMC_REG_ADDR, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, `IMC_REG_ADDR, 32'h0, 4'h0); chk(rv, 32'h3F3F3F3F);
    chk({31'h0, sens_violation}, 32'h0);
    complete_run();
  end
endmodule : tb
`default_nettype wire
